// ### hdl/host_bus_data_tenure_port.sv
// Purpose: Data tenure side of the host bus port of a bridge.
// Assumes: All pins synchronous to clk; pins active high inside.
// Notes:   Address tenure logic lives elsewhere; it starts tenures here.
// Summary of operation
// - Drive data for PCI reads, memory writes, flushes
// - Drive valid one clock after bus idle
// - Release bus cycle after final beat ack
// - Sample data for writes, reads, snoop copy-backs
// - Write-through attribute marks write-through access
// - Cache-inhibit attribute marks non-cacheable access
// - Coherent attribute demands hardware coherency
// - Ack once data latched or valid
// - Ack on completion, negate after last beat
// - Error ack suppressed when enable clear
// - Error ack ends transaction without ack
// - Unsupported accesses raise bus error
// - Error ack next clock, one clock long
// - Three shared pins: cache or second processor
// - 64-bit bus, two halves, lanes from top
// - Cache RAM enable while RAMs drive bus
`timescale 1ns/1ps
module host_bus_data_tenure_port
(
    // Clock and reset
    input  wire logic                                clk,
    input  wire logic                                nrst,
    // Tenure request from the address side
    input  wire logic                                tenure_start,
    input  wire data_tenure_pkg::xfer_kind_t         tenure_kind,
    input  wire logic [3:0]                          tenure_beats,
    input  wire logic                                error_ack_enable,
    input  wire data_tenure_pkg::share_mode_t        share_mode,
    output logic                                     tenure_busy,
    // Beat data from or to the core
    input  wire logic [data_tenure_pkg::BUS_W-1:0]   beat_wdata,
    input  wire logic                                beat_ready,
    output logic [data_tenure_pkg::BUS_W-1:0]        beat_rdata,
    output logic                                     beat_rvalid,
    // Bus status pins
    input  wire logic                                data_bus_busy,
    input  wire logic                                data_bus_grant,
    input  wire logic                                address_retry,
    // Attribute pins, three signals each
    input  wire logic                                write_through_attr_in,
    input  wire logic                                cache_inhibit_attr_in,
    input  wire logic                                coherent_access_attr_in,
    input  wire logic                                attr_drive_req,
    input  wire logic                                attr_wt_req,
    input  wire logic                                attr_ci_req,
    input  wire logic                                attr_gbl_req,
    output logic                                     write_through_attr_out,
    output logic                                     cache_inhibit_attr_out,
    output logic                                     coherent_access_attr_out,
    output logic                                     attr_oe,
    output logic                                     access_write_through,
    output logic                                     access_no_cache,
    output logic                                     access_coherent,
    // Beat acknowledge, two-way
    input  wire logic                                beat_ack_in,
    output logic                                     beat_ack_out,
    output logic                                     beat_ack_oe,
    // Error acknowledge and cache RAM enable
    output logic                                     beat_error_ack,
    output logic                                     cache_ram_output_enable,
    // Shared pins
    input  wire logic                                cache_dirty_flag,
    input  wire logic                                tag_oe_req,
    input  wire logic                                dirty_in_or_request_two,
    output logic                                     dirty_out_or_grant_two,
    output logic                                     tag_oe_or_data_grant_two,
    input  wire logic                                second_cpu_grant,
    input  wire logic                                second_cpu_data_grant,
    output logic                                     second_cpu_request,
    output logic                                     cache_dirty_in,
    // Data bus pins
    input  wire logic [data_tenure_pkg::HALF_W-1:0]  data_high_half_in,
    input  wire logic [data_tenure_pkg::HALF_W-1:0]  data_low_half_in,
    output logic      [data_tenure_pkg::HALF_W-1:0]  data_high_half_out,
    output logic      [data_tenure_pkg::HALF_W-1:0]  data_low_half_out,
    output logic                                     data_oe
);
    // ==========================================================
    // Declarations
    // ==========================================================
    data_tenure_pkg::port_state_t state_q;      // Sequencer state
    data_tenure_pkg::xfer_kind_t  kind_q;       // Kind of this tenure
    logic [3:0]                   beats_q;      // Beats left
    logic                         out_dir;      // Device drives data
    logic                         l2_src;       // Cache RAMs source data
    logic                         ack_now;      // Ack this cycle
    logic                         last_beat;    // Ack ends tenure
    logic                         grant_ok;     // Qualified grant seen
    logic                         ack_q;        // Registered ack
    logic                         bus_data_ok;  // Data present this beat
    beat_if                       lane();       // Link to data path

    // ==========================================================
    // Direction decode
    // ==========================================================
    // Drive for these three kinds, sample for the rest
    assign out_dir = (kind_q == data_tenure_pkg::XFER_PROC_RD_PCI) ||
                     (kind_q == data_tenure_pkg::XFER_PCI_WR_MEM)  ||
                     (kind_q == data_tenure_pkg::XFER_L2_FLUSH);
    // Snoop copy-back out of L2 comes from the cache RAMs
    assign l2_src  = (kind_q == data_tenure_pkg::XFER_SNOOP_CPBACK);
    // Grant counts only with bus not busy and no retry
    assign grant_ok = data_bus_grant && !data_bus_busy && !address_retry;
    // Processor data valid one clock after qualified grant
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            bus_data_ok <= 1'b0;
        else if (state_q != data_tenure_pkg::ST_BEAT)
            bus_data_ok <= 1'b0;
        else if (grant_ok || out_dir || l2_src)
            bus_data_ok <= 1'b1;
    end
    // Ack when core is ready and, when sampling, the data is on the pins
    assign ack_now   = (state_q == data_tenure_pkg::ST_BEAT) && beat_ready &&
                       (out_dir || bus_data_ok) && !ack_q;
    assign last_beat = (beats_q == 4'h1);

    // ==========================================================
    // Sequencer
    // ==========================================================
    // One tenure at a time; error path never issues an ack
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_q <= data_tenure_pkg::ST_IDLE;
            kind_q  <= data_tenure_pkg::XFER_PROC_RD_PCI;
            beats_q <= 4'h0;
        end
        else
        begin
            case (state_q)
                data_tenure_pkg::ST_IDLE:
                begin
                    if (tenure_start)
                    begin
                        kind_q  <= tenure_kind;
                        beats_q <= (tenure_beats == 4'h0) ? 4'h1 : tenure_beats;
                        if (tenure_kind == data_tenure_pkg::XFER_UNSUPPORTED)
                            state_q <= error_ack_enable ? data_tenure_pkg::ST_ERR
                                                        : data_tenure_pkg::ST_IDLE;
                        else
                            state_q <= data_tenure_pkg::ST_LEAD;
                    end
                end
                data_tenure_pkg::ST_LEAD:
                begin
                    // Wait until the bus is idle, then one lead clock
                    if (!data_bus_busy)
                        state_q <= data_tenure_pkg::ST_BEAT;
                end
                data_tenure_pkg::ST_BEAT:
                begin
                    if (ack_now)
                    begin
                        beats_q <= beats_q - 4'h1;
                        if (last_beat)
                            state_q <= data_tenure_pkg::ST_REL;
                    end
                end
                data_tenure_pkg::ST_ERR:
                    state_q <= data_tenure_pkg::ST_IDLE;
                data_tenure_pkg::ST_REL:
                    state_q <= data_tenure_pkg::ST_IDLE;
                default:
                    state_q <= data_tenure_pkg::ST_IDLE;
            endcase
        end
    end

    assign tenure_busy = (state_q != data_tenure_pkg::ST_IDLE);

    // ==========================================================
    // Acknowledge outputs
    // ==========================================================
    // Ack is registered: it appears the clock after ack_now
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            ack_q <= 1'b0;
        else
            ack_q <= ack_now;
    end
    assign beat_ack_out = ack_q;
    // Drive ack only while we own the tenure as slave
    assign beat_ack_oe  = (state_q == data_tenure_pkg::ST_BEAT) || ack_q;

    // Error ack: one clock after detection, one clock long, never with ack
    assign beat_error_ack = (state_q == data_tenure_pkg::ST_ERR) && error_ack_enable &&
                            !ack_q;

    // Cache RAMs drive only during a snoop copy-back beat
    assign cache_ram_output_enable = (state_q == data_tenure_pkg::ST_BEAT) && l2_src;

    // ==========================================================
    // Data path hookup
    // ==========================================================
    // Drive only during beats; releases the cycle after the last ack
    assign lane.drive   = (state_q == data_tenure_pkg::ST_BEAT) && out_dir;
    assign lane.wr_data = beat_wdata;
    assign lane.capture = ack_now && !out_dir;
    assign beat_rdata   = lane.rd_data;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            beat_rvalid <= 1'b0;
        else
            beat_rvalid <= lane.capture;
    end

    data_lane_path u_path
    (
        .clk                (clk),
        .nrst               (nrst),
        .bus                (lane.path),
        .data_high_half_in  (data_high_half_in),
        .data_low_half_in   (data_low_half_in),
        .data_high_half_out (data_high_half_out),
        .data_low_half_out  (data_low_half_out),
        .data_oe            (data_oe)
    );

    // ==========================================================
    // Transfer attributes
    // ==========================================================
    // Follow address timing: driven while the address side asks
    assign write_through_attr_out   = attr_wt_req;
    assign cache_inhibit_attr_out   = attr_ci_req;
    assign coherent_access_attr_out = attr_gbl_req;
    assign attr_oe                  = attr_drive_req;
    // Decoded meaning of the pin levels, ours or the master's
    assign access_write_through = attr_drive_req ? attr_wt_req
                                                 : write_through_attr_in;
    assign access_no_cache      = attr_drive_req ? attr_ci_req
                                                 : cache_inhibit_attr_in;
    assign access_coherent      = attr_drive_req ? attr_gbl_req
                                                 : coherent_access_attr_in;

    // ==========================================================
    // Shared pins
    // ==========================================================
    // Mode is static config; swapping it mid-tenure is not supported
    assign dirty_out_or_grant_two = (share_mode == data_tenure_pkg::SHARE_SECOND_CPU)
                                    ? second_cpu_grant : cache_dirty_flag;
    assign tag_oe_or_data_grant_two = (share_mode == data_tenure_pkg::SHARE_SECOND_CPU)
                                    ? second_cpu_data_grant : tag_oe_req;
    assign second_cpu_request = (share_mode == data_tenure_pkg::SHARE_SECOND_CPU) &&
                                dirty_in_or_request_two;
    assign cache_dirty_in     = (share_mode == data_tenure_pkg::SHARE_L2_CACHE) &&
                                dirty_in_or_request_two;
endmodule

// ### shared/data_tenure_pkg.sv
// Purpose: Constants and types shared by the host data tenure port.
// Assumes: One 200 MHz clock; bus pins active high inside the core.
// Notes:   Lane numbering runs from the top of the high half downward.
package data_tenure_pkg;

    // ==========================================================
    // Data bus shape
    // ==========================================================
    localparam int HALF_W  = 32;            // Width of one half
    localparam int BUS_W   = 2 * HALF_W;    // Full data bus width
    localparam int LANES   = BUS_W / 8;     // Byte lanes 0..7

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int CLK_PERIOD_NS = 5;       // 200 MHz clock
    localparam int IDLE_LEAD_CLK = 1;       // Drive valid one clock after idle
    localparam int ERR_HOLD_CLK  = 1;       // Error ack stands one clock

    // ==========================================================
    // Data tenure kinds
    // ==========================================================
    typedef enum logic [2:0] {
        XFER_PROC_RD_PCI  = 3'h0,           // Processor reads from PCI: drive
        XFER_PCI_WR_MEM   = 3'h1,           // PCI master writes memory: drive
        XFER_L2_FLUSH     = 3'h2,           // Copy-back buffer flush: drive
        XFER_PROC_WR_PCI  = 3'h3,           // Processor writes to PCI: sample
        XFER_PCI_RD_MEM   = 3'h4,           // PCI master reads memory: sample
        XFER_SNOOP_CPBACK = 3'h5,           // L1/L2 copy-back on snoop: sample
        XFER_UNSUPPORTED  = 3'h6            // Direct-store or graphics access
    } xfer_kind_t;

    // ==========================================================
    // Port state machine
    // ==========================================================
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,                    // No tenure
        ST_LEAD  = 3'h1,                    // Turnaround before drive
        ST_BEAT  = 3'h2,                    // Beats in progress
        ST_ERR   = 3'h3,                    // Error ack pulse
        ST_REL   = 3'h4                     // Release cycle after last ack
    } port_state_t;

    // Shared pin mode select
    typedef enum logic {
        SHARE_L2_CACHE = 1'b0,              // Pins serve lookaside cache
        SHARE_SECOND_CPU = 1'b1             // Pins serve second processor
    } share_mode_t;

endpackage

// ### shared/beat_if.sv
// Purpose: Beat handshake between the tenure sequencer and the data path.
// Assumes: Single clock domain.
// Notes:   Carries lane data both ways plus drive control.
`timescale 1ns/1ps
interface beat_if;
    logic [data_tenure_pkg::BUS_W-1:0] wr_data;   // Data to drive
    logic                              drive;     // Drive the pins
    logic                              capture;   // Latch pin data now
    logic [data_tenure_pkg::BUS_W-1:0] rd_data;   // Latched pin data

    modport seq  (output wr_data, output drive, output capture, input rd_data);
    modport path (input wr_data, input drive, input capture, output rd_data);
endinterface

// ### hdl/data_lane_path.sv
// Purpose: Registered data path for the 64-bit two-way data bus.
// Assumes: Pin input is synchronous to clk.
// Notes:   Output enable and output data both come from flip-flops.
`timescale 1ns/1ps
module data_lane_path
(
    // Clock and reset
    input  wire logic                              clk,
    input  wire logic                              nrst,
    // Sequencer side
    beat_if.path                                   bus,
    // Pin side, high half then low half
    input  wire logic [data_tenure_pkg::HALF_W-1:0] data_high_half_in,
    input  wire logic [data_tenure_pkg::HALF_W-1:0] data_low_half_in,
    output logic      [data_tenure_pkg::HALF_W-1:0] data_high_half_out,
    output logic      [data_tenure_pkg::HALF_W-1:0] data_low_half_out,
    output logic                                    data_oe
);
    // ==========================================================
    // Output drive
    // ==========================================================
    // Registered so the enable never glitches onto a shared bus
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            data_high_half_out <= '0;
            data_low_half_out  <= '0;
            data_oe            <= 1'b0;
        end
        else
        begin
            data_oe <= bus.drive;
            // Lane 0 sits at the top of the high half
            data_high_half_out <= bus.wr_data[data_tenure_pkg::BUS_W-1:data_tenure_pkg::HALF_W];
            data_low_half_out  <= bus.wr_data[data_tenure_pkg::HALF_W-1:0];
        end
    end

    // ==========================================================
    // Input capture
    // ==========================================================
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            bus.rd_data <= '0;
        else if (bus.capture)
            bus.rd_data <= {data_high_half_in, data_low_half_in};
    end
endmodule

// ### tb/host_bus_data_tenure_port_props.sv
// Purpose: Pin-level checks on the host bus data tenure port.
// Assumes: One clock; nrst asynchronous, active low.
// Notes:   Bound into the port by the statement at the foot.
`timescale 1ns/1ps
module host_bus_data_tenure_port_props
(
    // Clock, reset, tenure request
    input wire logic                        clk, nrst, tenure_start, tenure_busy,
    input wire data_tenure_pkg::xfer_kind_t tenure_kind,
    input wire logic                        error_ack_enable, data_bus_busy,
    // Handshake and drive
    input wire logic                        beat_ack_out, beat_error_ack, data_oe
);
    // ==========================
    // Helpers
    default clocking dc @(posedge clk); endclocking
    default disable iff (!nrst);
    logic bad_kind; // Unsupported tenure taken at this edge
    assign bad_kind = tenure_start && !tenure_busy
                      && tenure_kind == data_tenure_pkg::XFER_UNSUPPORTED;
    // ==========================
    // Assertions
    ack_excl_a: assert property (!(beat_ack_out && beat_error_ack))
        else $error("ack and error ack together");
    err_pulse_a: assert property ($rose(beat_error_ack) |=> !beat_error_ack)
        else $error("error ack longer than one clock");
    err_gate_a: assert property (beat_error_ack |-> error_ack_enable)
        else $error("error ack while disabled");
    err_next_a: assert property (bad_kind && error_ack_enable |=> beat_error_ack)
        else $error("no error ack after unsupported access");
    no_ack_a: assert property (bad_kind |=> !beat_ack_out [*4])
        else $error("ack on an errored access");
    ack_gap_a: assert property (beat_ack_out |=> !beat_ack_out)
        else $error("acks back to back");
    bus_release_a: assert property ($fell(data_oe) |-> $past(beat_ack_out))
        else $error("bus released without a final ack");
    idle_lead_a: assert property ($rose(data_oe) |-> !$past(data_bus_busy, 2))
        else $error("drive began without an idle clock");
endmodule

bind host_bus_data_tenure_port host_bus_data_tenure_port_props chk_i (.*);

// ### tb/host_proc_model.sv
// Purpose: Behavioural host processor on the far side of the data bus.
// Assumes: One write beat per grant; the bench asks for the grant.
// Notes:   Released lines drift to the inverse of their last level.
`timescale 1ns/1ps
module host_proc_model
(
    // Clock, reset and bench control
    input wire logic        clk, nrst, grant_go,
    input wire logic [63:0] wr_pattern,
    // Port side of the bus
    input wire logic        data_oe, beat_ack_out,
    input wire logic [31:0] hi_out, lo_out,
    output logic            data_bus_grant, m_busy, address_retry,
    output logic [31:0]     hi_in, lo_in
);
    logic        drive_q; // Processor owns the data lines
    logic [63:0] last_q;  // Last level, so a floating bus never looks stable
    logic [63:0] bus;     // Resolved wire level
    assign address_retry = 1'h0;
    assign m_busy = drive_q;
    assign bus = data_oe ? {hi_out, lo_out} : (drive_q ? wr_pattern : ~last_q);
    assign {hi_in, lo_in} = bus;
    // Grant for one clock with the bus idle, data from the next clock until acked
    always_ff @(posedge clk or negedge nrst)
        if (!nrst)
        begin
            data_bus_grant <= 1'h0;
            drive_q        <= 1'h0;
            last_q         <= 64'h0;
        end
        else
        begin
            data_bus_grant <= grant_go;
            last_q         <= bus;
            if (data_bus_grant)
                drive_q <= 1'h1;
            else if (beat_ack_out)
                drive_q <= 1'h0;
        end
endmodule

// ### tb/tb_host_bus_data_tenure_port.sv
// Purpose: Self-checking bench for the host bus data tenure port.
// Assumes: 200 MHz clock; host model drives the far side of the bus.
// Notes:   External slave ack is not modelled, so its input stays low.
`timescale 1ns/1ps
module tb_host_bus_data_tenure_port;
    logic clk, nrst, tenure_start, tenure_busy, error_ack_enable, beat_ready, beat_rvalid;
    data_tenure_pkg::xfer_kind_t  tenure_kind;
    data_tenure_pkg::share_mode_t share_mode;
    logic [3:0]  tenure_beats;
    logic [63:0] beat_wdata, beat_rdata, pat;
    logic data_bus_busy, m_busy, tb_busy, grant_go, data_bus_grant, address_retry;
    logic write_through_attr_in, cache_inhibit_attr_in, coherent_access_attr_in;
    logic attr_drive_req, attr_wt_req, attr_ci_req, attr_gbl_req, attr_oe;
    logic write_through_attr_out, cache_inhibit_attr_out, coherent_access_attr_out;
    logic access_write_through, access_no_cache, access_coherent, beat_ack_in;
    logic beat_ack_out, beat_ack_oe, beat_error_ack, cache_ram_output_enable;
    logic cache_dirty_flag, tag_oe_req, dirty_in_or_request_two, dirty_out_or_grant_two;
    logic tag_oe_or_data_grant_two, second_cpu_grant, second_cpu_data_grant;
    logic second_cpu_request, cache_dirty_in, data_oe;
    logic [31:0] data_high_half_in, data_low_half_in, data_high_half_out, data_low_half_out;
    int miscompares = 0;  // Mismatches seen
    int total_checks = 0; // Comparisons made
    wire logic [3:0] attr_drv = {attr_oe, write_through_attr_out, cache_inhibit_attr_out,
                                 coherent_access_attr_out};
    assign data_bus_busy = m_busy | tb_busy; // Bench may hold the bus busy
    host_bus_data_tenure_port dut (.*);
    host_proc_model proc (.clk, .nrst, .grant_go, .wr_pattern(pat), .data_oe, .beat_ack_out,
        .hi_out(data_high_half_out), .lo_out(data_low_half_out), .data_bus_grant, .m_busy,
        .address_retry, .hi_in(data_high_half_in), .lo_in(data_low_half_in));
    initial
    begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end
    // Compare, count and report
    task chk(input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task hang;
        miscompares++;
        end_sim();
    endtask
    // Wait for idle, then hand over one tenure request
    task go(input int k, input logic [3:0] b);
        int n;
        for (n = 0; n < 40 && tenure_busy !== 1'h0; n++) @(negedge clk);
        if (n == 40) hang();
        @(posedge clk) {tenure_start, tenure_beats} <= {1'h1, b};
        tenure_kind <= data_tenure_pkg::xfer_kind_t'(k[2:0]);
        @(posedge clk) tenure_start <= 1'h0;
    endtask
    // Device drives; first kind waits out a busy bus, beats counted to the last
    task t_drive(input int k, input logic [3:0] b);
        int n, acks;
        acks = 0;
        @(posedge clk) beat_wdata <= 64'h0123_4567_89ab_cdef ^ 64'(k);
        tb_busy <= (k == 0);
        go(k, b);
        if (k == 0)
        begin
            repeat (3) @(negedge clk) chk({data_oe, tenure_busy}, 2'h1);
            @(posedge clk) tb_busy <= 1'h0;
        end
        for (n = 0; n < 40 && acks < ((b == 0) ? 1 : b); n++)
        begin
            @(negedge clk);
            if (beat_ack_out === 1'h1)
            begin
                acks++;
                chk({data_oe, beat_ack_oe}, 2'h3);
                chk({data_high_half_out, data_low_half_out}, beat_wdata);
            end
        end
        if (n == 40) hang();
        @(negedge clk) chk({data_oe, beat_ack_oe, tenure_busy}, 3'h0);
    endtask
    // Processor writes after its grant; the port captures without driving
    task t_samp(input int k);
        int n;
        logic l2oe; // Cache RAM enable seen during the tenure
        l2oe = 1'h0;
        @(posedge clk) pat <= 64'hfeed_0000_1357_9bdf ^ 64'(k);
        go(k, 4'h1);
        grant_go <= 1'h1;
        @(posedge clk) grant_go <= 1'h0;
        for (n = 0; n < 40 && beat_rvalid !== 1'h1; n++)
            @(negedge clk) l2oe |= cache_ram_output_enable;
        if (n == 40) hang();
        chk(l2oe, k == 5);
        chk(beat_rdata, pat);
        chk(data_oe, 1'h0);
    endtask
    // Unsupported access: error ack only when enabled, never a beat ack
    task t_err(input logic en);
        @(posedge clk) error_ack_enable <= en;
        go(6, 4'h1);
        for (int n = 0; n < 4; n++)
        begin
            @(negedge clk) chk(beat_error_ack, en && n == 0);
            chk(beat_ack_out, 1'h0);
        end
    endtask
    // Shared pins follow the mode; attributes pass through or decode the pins
    task t_pins;
        for (int m = 0; m < 2; m++)
        begin
            @(posedge clk) share_mode <= data_tenure_pkg::share_mode_t'(m[0]);
            {cache_dirty_flag, tag_oe_req, attr_drive_req} <= {m == 0, m == 0, m == 1};
            {second_cpu_grant, second_cpu_data_grant} <= {m == 1, m == 1};
            dirty_in_or_request_two <= 1'h1;
            {attr_wt_req, attr_ci_req, attr_gbl_req} <= 3'h5;
            {write_through_attr_in, cache_inhibit_attr_in, coherent_access_attr_in} <= 3'h3;
            @(negedge clk);
            chk({dirty_out_or_grant_two, tag_oe_or_data_grant_two}, 2'h3);
            chk({second_cpu_request, cache_dirty_in}, m ? 2'h2 : 2'h1);
            if (m) chk(attr_drv, 4'hd);
            // Decode follows our own request while driving, the pins otherwise
            chk({attr_oe, access_write_through, access_no_cache, access_coherent},
                m ? 4'hd : 4'h3);
        end
    endtask
    // Main sequence
    initial
    begin
        {nrst, tenure_start, error_ack_enable, tb_busy, grant_go} = 5'h0;
        beat_ack_in = 1'h0;
        {write_through_attr_in, cache_inhibit_attr_in, coherent_access_attr_in} = 3'h0;
        {attr_drive_req, attr_wt_req, attr_ci_req, attr_gbl_req} = 4'h0;
        {cache_dirty_flag, tag_oe_req, dirty_in_or_request_two} = 3'h0;
        {second_cpu_grant, second_cpu_data_grant} = 2'h0;
        tenure_kind = data_tenure_pkg::XFER_PROC_RD_PCI;
        share_mode = data_tenure_pkg::SHARE_L2_CACHE;
        {tenure_beats, beat_wdata, pat} = '0;
        beat_ready = 1'h1;
        repeat (5) @(posedge clk);
        nrst <= 1'h1;
        t_drive(0, 4'h2);
        t_drive(1, 4'h0);
        t_drive(2, 4'h2);
        for (int k = 3; k < 6; k++) t_samp(k);
        t_err(1'h1);
        t_err(1'h0);
        t_pins();
        end_sim();
    end
endmodule
